// [design/aptic_pkg.sv]
// Package for the converter control two block: register map, field layout, reset values.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package aptic_pkg;

    // Byte offsets of the registers
    localparam logic [7:0] APTIC_OFS_CTL2 = 8'h00;
    localparam logic [7:0] APTIC_OFS_TRIG_SRC = 8'h04;
    localparam logic [7:0] APTIC_OFS_EVT_STAT = 8'h08;
    localparam logic [7:0] APTIC_OFS_EVT_MASK = 8'h0C;
    localparam logic [7:0] APTIC_OFS_CONV_STAT = 8'h10;

    // Layout of converter_control_two, bit 7 down to bit 0
    typedef struct packed {
        logic analog_power_up;
        logic fast_flag_clear;
        logic wait_power_down;
        logic trigger_level_select;
        logic trigger_polarity;
        logic external_trigger_enable;
        logic sequence_irq_enable;
        logic sequence_irq_flag;
    } aptic_ctl_s;

    // Trigger source select: kind bit and channel field
    typedef struct packed {
        logic trigger_source_kind;
        logic [2:0] trigger_channel_select;
    } aptic_src_s;

    // Event status and mask layout
    typedef struct packed {
        logic trigger_event;
        logic sequence_complete_flag;
    } aptic_evt_s;

    localparam aptic_ctl_s APTIC_CTL_RST = 8'h00;
    localparam aptic_src_s APTIC_SRC_RST = 4'h0;
    localparam aptic_evt_s APTIC_EVT_RST = 2'h0;
    localparam logic [1:0] APTIC_DEDICATED_LAST = 2'h3;
    localparam logic [31:0] APTIC_RD_ZERO = 32'h0000_0000;

endpackage : aptic_pkg

// [design/aptic_sync.sv]
// Two flip-flop synchroniser for a bus of asynchronous levels.
// Assumes the inputs are quasi-static relative to clk_i.
`timescale 1ns/1ns
module aptic_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Levels
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    initial begin
        if (WIDTH < 1) begin
            $error("aptic_sync: WIDTH must be at least 1");
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;

endmodule : aptic_sync

// [design/aptic_ctl.sv]
// Converter control two: power, flag clearing, wait power-down, external trigger, sequence irq.
// Assumes a classic Wishbone master on clk_i; trigger pins are asynchronous.
// How it works
// - Any control write with byte lane 0 selected aborts, never starts, sequence
// - Bit 7 set powers converter up
// - Normal clear: status read, then result read
// - Fast clear: result access clears its flag
// - Bit 5 halts, powers down in wait
// - Halted conversion resumes; its result discarded
// - Bits 4,3 pick edge or level, polarity
// - Bit 2 enables synchronised external trigger
// - Analog trigger channel gets digital buffer
// - Irq requested while enable and flag set
// - Bit 0 reads flag when enabled, else zero
// - Writes to bit 0 have no effect
// - Kind bit plus channel field pick source
`timescale 1ns/1ns
module aptic_ctl
    import aptic_pkg::*;
#(
    parameter int CHANNELS = 8,
    parameter int DEDICATED = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Sequencer status and result accesses
    input wire logic seq_done_i,
    input wire logic [CHANNELS-1:0] conv_done_i,
    input wire logic result_access_i,
    input wire logic [2:0] result_index_i,
    input wire logic wait_mode_i,
    // Analog channels and dedicated trigger pins
    input wire logic [CHANNELS-1:0] analog_level_i,
    input wire logic [DEDICATED-1:0] dedicated_trigger_inputs_i,
    // Converter control
    output logic abort_o,
    output logic converter_on_o,
    output logic conversion_halt_o,
    output logic discard_result_o,
    output logic trigger_o,
    output logic [CHANNELS-1:0] digital_buffer_en_o,
    output logic [CHANNELS-1:0] conversion_complete_flag_o,
    output logic irq_o
);
    initial begin
        if (CHANNELS != 8 || DEDICATED < 1 || DEDICATED > 4) begin
            $error("aptic_ctl: CHANNELS must be 8 and DEDICATED 1 to 4");
        end
    end

    // Register state
    aptic_ctl_s ctl_r, ctl_nxt;
    aptic_src_s src_r, src_nxt;
    aptic_evt_s stat_r, stat_nxt;
    logic trig_mask_r, trig_mask_nxt;
    logic [CHANNELS-1:0] ccf_r, ccf_nxt;
    logic armed_r, armed_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic abort_r, abort_nxt;
    logic halted_r, halted_nxt;
    logic discard_r, discard_nxt;
    logic trig_prev_r, trig_prev_nxt;
    logic trig_r, trig_nxt;

    // Synchronised trigger candidates
    logic [CHANNELS-1:0] analog_s;
    logic [DEDICATED-1:0] dedicated_s;

    aptic_sync #(.WIDTH(CHANNELS)) u_sync_analog (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(analog_level_i),
        .sync_o(analog_s)
    );
    aptic_sync #(.WIDTH(DEDICATED)) u_sync_dedicated (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(dedicated_trigger_inputs_i),
        .sync_o(dedicated_s)
    );

    // Bus decode
    logic req, wr, rd, wr_lane0;
    logic sel_valid, sel_level;
    logic halt;
    logic [CHANNELS-1:0] ccf_clr;

    always_comb begin
        req = wb_cyc_i && wb_stb_i && !ack_r;
        wr = req && wb_we_i;
        rd = req && !wb_we_i;
        wr_lane0 = wr && wb_sel_i[0];
        halt = wait_mode_i && ctl_r.wait_power_down;
        // Trigger source selection, reserved codes select nothing
        sel_valid = 1'b1;
        sel_level = 1'b0;
        if (!src_r.trigger_source_kind) begin
            sel_level = analog_s[src_r.trigger_channel_select];
        end else if (!src_r.trigger_channel_select[2] &&
                     int'(src_r.trigger_channel_select[1:0]) < DEDICATED) begin
            sel_level = dedicated_s[src_r.trigger_channel_select[1:0]];
        end else begin
            sel_valid = 1'b0;
        end
        ccf_clr = '0;
        if (result_access_i && (ctl_r.fast_flag_clear || armed_r)) begin
            ccf_clr[result_index_i] = 1'b1;
        end
    end

    always_comb begin
        ctl_nxt = ctl_r;
        src_nxt = src_r;
        stat_nxt = stat_r;
        trig_mask_nxt = trig_mask_r;
        armed_nxt = armed_r;
        ack_nxt = req;
        dat_nxt = APTIC_RD_ZERO;
        abort_nxt = 1'b0;
        halted_nxt = halt;
        discard_nxt = discard_r;
        trig_prev_nxt = sel_level;
        trig_nxt = 1'b0;

        // Writes
        if (wr_lane0) begin
            case (wb_adr_i)
                APTIC_OFS_CTL2: begin
                    ctl_nxt = aptic_ctl_s'(wb_dat_i[7:0]);
                    ctl_nxt.sequence_irq_flag = 1'b0;
                    abort_nxt = 1'b1;
                end
                APTIC_OFS_TRIG_SRC: begin
                    src_nxt = aptic_src_s'(wb_dat_i[3:0]);
                end
                APTIC_OFS_EVT_STAT: begin
                    stat_nxt = stat_r & ~aptic_evt_s'(wb_dat_i[1:0]);
                end
                APTIC_OFS_EVT_MASK: begin
                    trig_mask_nxt = wb_dat_i[1];
                    ctl_nxt.sequence_irq_enable = wb_dat_i[0];
                end
                default: abort_nxt = 1'b0;
            endcase
        end

        // Reads
        if (rd) begin
            case (wb_adr_i)
                APTIC_OFS_CTL2: begin
                    dat_nxt[7:0] = ctl_r;
                    dat_nxt[0] = ctl_r.sequence_irq_enable && stat_r.sequence_complete_flag;
                end
                APTIC_OFS_TRIG_SRC: dat_nxt[3:0] = src_r;
                APTIC_OFS_EVT_STAT: dat_nxt[1:0] = stat_r;
                APTIC_OFS_EVT_MASK: dat_nxt[1:0] = {trig_mask_r, ctl_r.sequence_irq_enable};
                APTIC_OFS_CONV_STAT: begin
                    dat_nxt[CHANNELS-1:0] = ccf_r;
                    armed_nxt = 1'b1;
                end
                default: dat_nxt = APTIC_RD_ZERO;
            endcase
        end
        if (result_access_i && !ctl_r.fast_flag_clear && armed_r) begin
            armed_nxt = 1'b0;
        end

        // Trigger detection on the synchronised level
        if (ctl_r.external_trigger_enable && ctl_r.analog_power_up && !halt && sel_valid) begin
            if (ctl_r.trigger_level_select) begin
                trig_nxt = (sel_level == ctl_r.trigger_polarity);
            end else if (ctl_r.trigger_polarity) begin
                trig_nxt = sel_level && !trig_prev_r;
            end else begin
                trig_nxt = !sel_level && trig_prev_r;
            end
        end

        // Sticky events, set wins over clear
        if (seq_done_i) begin
            stat_nxt.sequence_complete_flag = 1'b1;
        end
        if (trig_nxt && !trig_r) begin
            stat_nxt.trigger_event = 1'b1;
        end

        // Wait exit resumes; its first result is flagged for discard
        if (halted_r && !halt) begin
            discard_nxt = 1'b1;
        end else if (|conv_done_i) begin
            discard_nxt = 1'b0;
        end
    end

    // Conversion complete flags, set wins over clear
    assign ccf_nxt = (ccf_r & ~ccf_clr) | conv_done_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_r <= APTIC_CTL_RST;
            src_r <= APTIC_SRC_RST;
            stat_r <= APTIC_EVT_RST;
            trig_mask_r <= 1'b0;
            ccf_r <= '0;
            armed_r <= 1'b0;
            ack_r <= 1'b0;
            dat_r <= APTIC_RD_ZERO;
            abort_r <= 1'b0;
            halted_r <= 1'b0;
            discard_r <= 1'b0;
            trig_prev_r <= 1'b0;
            trig_r <= 1'b0;
        end else begin
            ctl_r <= ctl_nxt;
            src_r <= src_nxt;
            stat_r <= stat_nxt;
            trig_mask_r <= trig_mask_nxt;
            ccf_r <= ccf_nxt;
            armed_r <= armed_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            abort_r <= abort_nxt;
            halted_r <= halted_nxt;
            discard_r <= discard_nxt;
            trig_prev_r <= trig_prev_nxt;
            trig_r <= trig_nxt;
        end
    end

    // Outputs
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign abort_o = abort_r;
    assign converter_on_o = ctl_r.analog_power_up && !halted_r;
    assign conversion_halt_o = halted_r;
    assign discard_result_o = discard_r;
    assign trigger_o = trig_r;
    assign conversion_complete_flag_o = ccf_r;
    always_comb begin
        digital_buffer_en_o = '0;
        if (ctl_r.external_trigger_enable && !src_r.trigger_source_kind) begin
            digital_buffer_en_o[src_r.trigger_channel_select] = 1'b1;
        end
    end
    assign irq_o = (ctl_r.sequence_irq_enable && stat_r.sequence_complete_flag) ||
                   (trig_mask_r && stat_r.trigger_event);

    // Checks
    property p_abort;
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i == APTIC_OFS_CTL2)
            |=> abort_o ##1 !abort_o;
    endproperty
    a_abort: assert property (p_abort) else $error("control write did not abort once");

    property p_power;
        @(posedge clk_i) disable iff (rst_i)
        !ctl_r.analog_power_up |-> !converter_on_o;
    endproperty
    a_power: assert property (p_power) else $error("converter on while powered down");

    property p_wait;
        @(posedge clk_i) disable iff (rst_i)
        (wait_mode_i && ctl_r.wait_power_down) |=> conversion_halt_o && !converter_on_o;
    endproperty
    a_wait: assert property (p_wait) else $error("wait power-down not honoured");

    property p_resume;
        @(posedge clk_i) disable iff (rst_i)
        $fell(conversion_halt_o) |-> discard_result_o;
    endproperty
    a_resume: assert property (p_resume) else $error("resume not flagged for discard");

    property p_edge_once;
        @(posedge clk_i) disable iff (rst_i)
        (!ctl_r.trigger_level_select && trigger_o) |=> !trigger_o;
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("edge trigger longer than one cycle");

    property p_buffer;
        @(posedge clk_i) disable iff (rst_i)
        (ctl_r.external_trigger_enable && !src_r.trigger_source_kind)
            |-> digital_buffer_en_o[src_r.trigger_channel_select];
    endproperty
    a_buffer: assert property (p_buffer) else $error("trigger channel buffer off");

    property p_irq;
        @(posedge clk_i) disable iff (rst_i)
        irq_o == ((ctl_r.sequence_irq_enable && stat_r.sequence_complete_flag) ||
                  (trig_mask_r && stat_r.trigger_event));
    endproperty
    a_irq: assert property (p_irq) else $error("irq output wrong");

    property p_flag_read;
        @(posedge clk_i) disable iff (rst_i)
        (rd && wb_adr_i == APTIC_OFS_CTL2)
            |=> wb_ack_o && wb_dat_o[0] == $past(ctl_r.sequence_irq_enable && stat_r.sequence_complete_flag);
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("irq flag readback wrong");

    property p_flag_ro;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> !ctl_r.sequence_irq_flag;
    endproperty
    a_flag_ro: assert property (p_flag_ro) else $error("irq flag bit stored a write");

    property p_fast_clear;
        @(posedge clk_i) disable iff (rst_i)
        (ctl_r.fast_flag_clear && result_access_i && !conv_done_i[result_index_i])
            |=> !conversion_complete_flag_o[$past(result_index_i)];
    endproperty
    a_fast_clear: assert property (p_fast_clear) else $error("fast clear missed");

    property p_normal_hold;
        @(posedge clk_i) disable iff (rst_i)
        (!ctl_r.fast_flag_clear && !armed_r && conversion_complete_flag_o[result_index_i] && result_access_i)
            |=> conversion_complete_flag_o[$past(result_index_i)];
    endproperty
    a_normal_hold: assert property (p_normal_hold) else $error("flag cleared without status read");

endmodule : aptic_ctl

// [verif/aptic_far_model.sv]
// Far-side model: digital levels of the analog channels and the dedicated trigger pins.
// Assumes the bench calls set_pin right after a rising edge of clk_i.
`timescale 1ns/1ns
module aptic_far_model (
    // Clock
    input wire logic clk_i,
    // Pin levels
    output logic [7:0] analog_level_o,
    output logic [3:0] dedicated_o
);
    initial begin
        analog_level_o = 8'h00;
        dedicated_o = 4'h0;
    end

    // A channel used as trigger carries only a digital level, never a result
    task automatic set_pin(input logic kind, input logic [2:0] ch, input logic val);
        @(negedge clk_i);
        @(posedge clk_i);
        if (kind) begin
            dedicated_o[ch[1:0]] <= val;
        end else begin
            analog_level_o[ch] <= val;
        end
    endtask : set_pin
endmodule : aptic_far_model

// [verif/aptic_ctl_tb.sv]
// Self-checking bench for the converter control two block.
// Assumes the design acks one cycle after a request and that trigger pins need 3 cycles.
`timescale 1ns/1ns
module aptic_ctl_tb
    import aptic_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic seq_done_i = 1'b0;
    logic [7:0] conv_done_i = 8'h00;
    logic result_access_i = 1'b0;
    logic [2:0] result_index_i = 3'h0;
    logic wait_mode_i = 1'b0;
    logic [7:0] analog_level_i;
    logic [3:0] dedicated_trigger_inputs_i;
    logic abort_o, converter_on_o, conversion_halt_o, discard_result_o, trigger_o, irq_o;
    logic [7:0] digital_buffer_en_o;
    logic [7:0] conversion_complete_flag_o;
    logic ab;
    int bad_count = 0;
    int checked = 0;

    always #5 clk_i = ~clk_i;

    aptic_ctl i_aptic_ctl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .seq_done_i(seq_done_i), .conv_done_i(conv_done_i),
        .result_access_i(result_access_i), .result_index_i(result_index_i), .wait_mode_i(wait_mode_i),
        .analog_level_i(analog_level_i), .dedicated_trigger_inputs_i(dedicated_trigger_inputs_i),
        .abort_o(abort_o), .converter_on_o(converter_on_o), .conversion_halt_o(conversion_halt_o),
        .discard_result_o(discard_result_o), .trigger_o(trigger_o), .digital_buffer_en_o(digital_buffer_en_o),
        .conversion_complete_flag_o(conversion_complete_flag_o), .irq_o(irq_o));

    aptic_far_model i_aptic_far_model (.clk_i(clk_i), .analog_level_o(analog_level_i),
        .dedicated_o(dedicated_trigger_inputs_i));

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // One classic cycle, entered right after a rising edge; leaves one idle cycle
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            bad_count++;
            $display("[ERR] bus ack expected 1 seen %b", wb_ack_o);
            end_of_test();
        end
        rd = wb_dat_o;
        ab = abort_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        bus(1'b1, adr, dat, d);
    endtask : wr

    task automatic rd32(input logic [7:0] adr, output logic [31:0] d);
        bus(1'b0, adr, 32'h0, d);
    endtask : rd32

    task automatic pulse_conv(input logic [7:0] m);
        conv_done_i <= m;
        tick(1);
        conv_done_i <= 8'h00;
        tick(2);
    endtask : pulse_conv

    task automatic access(input logic [2:0] i);
        result_index_i <= i;
        result_access_i <= 1'b1;
        tick(1);
        result_access_i <= 1'b0;
        tick(2);
    endtask : access

    task automatic t_reset();
        logic [31:0] d;
        for (int a = 0; a < 5; a++) begin
            rd32(8'(a * 4), d);
            chk("register reset", d, APTIC_RD_ZERO);
        end
        rd32(8'h40, d);
        chk("unmapped read", d, APTIC_RD_ZERO);
        chk("irq after reset", 32'(irq_o), 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_write();
        logic [31:0] d;
        wr(APTIC_OFS_CTL2, 32'h83);
        chk("abort on write", 32'(ab), 32'h1);
        chk("abort one cycle", 32'(abort_o), 32'h0);
        chk("power up", 32'(converter_on_o), 32'h1);
        rd32(APTIC_OFS_CTL2, d);
        chk("flag write ignored", d, 32'h82);
        chk("no abort on read", 32'(ab), 32'h0);
        wr(APTIC_OFS_CTL2, 32'h00);
        chk("power down", 32'(converter_on_o), 32'h0);
        $display("test write done");
    endtask : t_write

    task automatic t_flags();
        logic [31:0] d;
        wr(APTIC_OFS_CTL2, 32'h80);
        access(3'h0);
        pulse_conv(8'h20);
        chk("flag set", 32'(conversion_complete_flag_o), 32'h20);
        access(3'h5);
        chk("flag kept unarmed", 32'(conversion_complete_flag_o), 32'h20);
        rd32(APTIC_OFS_CONV_STAT, d);
        chk("status second", d, 32'h20);
        access(3'h5);
        chk("normal clear", 32'(conversion_complete_flag_o), 32'h0);
        wr(APTIC_OFS_CTL2, 32'hC0);
        pulse_conv(8'h04);
        chk("flag set fast", 32'(conversion_complete_flag_o), 32'h04);
        access(3'h2);
        chk("fast clear", 32'(conversion_complete_flag_o), 32'h0);
        $display("test flags done");
    endtask : t_flags

    task automatic t_wait();
        wr(APTIC_OFS_CTL2, 32'h80);
        wait_mode_i <= 1'b1;
        tick(3);
        chk("runs in wait", 32'(conversion_halt_o), 32'h0);
        wait_mode_i <= 1'b0;
        wr(APTIC_OFS_CTL2, 32'hA0);
        tick(8);
        wait_mode_i <= 1'b1;
        tick(3);
        chk("halt in wait", 32'(conversion_halt_o), 32'h1);
        chk("off in wait", 32'(converter_on_o), 32'h0);
        wait_mode_i <= 1'b0;
        tick(3);
        chk("resume", 32'(converter_on_o), 32'h1);
        chk("discard set", 32'(discard_result_o), 32'h1);
        pulse_conv(8'h01);
        chk("discard cleared", 32'(discard_result_o), 32'h0);
        $display("test wait done");
    endtask : t_wait

    task automatic t_trig(input logic kind, input logic [2:0] ch, input logic [1:0] m, input logic en,
                          input logic hit);
        int n;
        logic [31:0] d;
        wr(APTIC_OFS_TRIG_SRC, {28'h0, kind, ch});
        i_aptic_far_model.set_pin(kind, ch, ~m[0]);
        tick(6);
        wr(APTIC_OFS_CTL2, {24'h0, 1'b1, 2'b00, m, en, 2'b00});
        tick(6);
        wr(APTIC_OFS_EVT_STAT, 32'h2);
        i_aptic_far_model.set_pin(kind, ch, m[0]);
        n = 0;
        repeat (10) begin
            @(posedge clk_i);
            n += int'(trigger_o === 1'b1);
        end
        if (!m[1]) chk("edge events", 32'(n), 32'(hit));
        chk("level trigger", 32'(trigger_o), 32'(hit & m[1]));
        chk("buffer enable", 32'(digital_buffer_en_o), (en && !kind) ? 32'h1 << ch : 32'h0);
        rd32(APTIC_OFS_EVT_STAT, d);
        chk("trigger event", d, 32'(hit) << 1);
        i_aptic_far_model.set_pin(kind, ch, ~m[0]);
        tick(6);
        chk("trigger idle", 32'(trigger_o), 32'h0);
    endtask : t_trig

    task automatic t_irq();
        logic [31:0] d;
        wr(APTIC_OFS_EVT_STAT, 32'h3);
        wr(APTIC_OFS_CTL2, 32'h82);
        seq_done_i <= 1'b1;
        tick(1);
        seq_done_i <= 1'b0;
        tick(2);
        chk("irq raised", 32'(irq_o), 32'h1);
        rd32(APTIC_OFS_CTL2, d);
        chk("flag mirrors", d, 32'h83);
        wr(APTIC_OFS_CTL2, 32'h81);
        chk("irq masked", 32'(irq_o), 32'h0);
        rd32(APTIC_OFS_CTL2, d);
        chk("flag reads zero", d, 32'h80);
        wr(APTIC_OFS_EVT_MASK, 32'h1);
        chk("irq via mask", 32'(irq_o), 32'h1);
        wr(APTIC_OFS_EVT_STAT, 32'h1);
        chk("irq cleared", 32'(irq_o), 32'h0);
        rd32(APTIC_OFS_CTL2, d);
        chk("flag after clear", d, 32'h82);
        $display("test irq done");
    endtask : t_irq

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_write();
        t_flags();
        t_wait();
        for (int m = 0; m < 4; m++) begin
            t_trig(1'b0, 3'h3, 2'(m), 1'b1, 1'b1);
        end
        t_trig(1'b1, 3'h2, 2'b01, 1'b1, 1'b1);
        t_trig(1'b1, 3'h4, 2'b01, 1'b1, 1'b0);
        t_trig(1'b0, 3'h6, 2'b01, 1'b0, 1'b0);
        $display("test trigger done");
        t_irq();
        end_of_test();
    end
endmodule : aptic_ctl_tb
